// [rtl/pbs_cfg.svh]
// Offsets, field positions, reset values and select limits of the budget and status registers.
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

`define PBS_ADDR_W 12
`define PBS_BDV_BASE 12'h300
`define PBS_BDV_LAST 12'h31c
`define PBS_SWITCH_STATUS 12'h400
`define PBS_SYSTEM_CONTROL 12'h404
`define PBS_DATA_VALUE_SELECT 12'h408
`define PBS_BDATA 12'h40c
`define PBS_SYSTEM_CONTROL_UNLOCK_BIT 0
`define PBS_SYSTEM_CONTROL_RESET 32'h0000_0000
`define PBS_DATA_VALUE_SELECT_RESET 8'h00
`define PBS_DATA_VALUE_SELECT_MAX 8'h07
`define PBS_NUM_BDV 8
`define PBS_MODE_LSB 0
`define PBS_RSVD_BIT 4
`define PBS_DOWNSTREAM_COMMON_CLOCK_BIT 5
`define PBS_UPSTREAM_COMMON_CLOCK_BIT 6
`define PBS_SMBSLOW_BIT 7
`define PBS_REFCLK_BIT 8
`define PBS_RESET_HALT_STRAP_BIT 9

`endif

// [rtl/pbs_pkg.sv]
// Types shared by the budget and status register files.
package pbs_pkg;
  typedef logic [31:0] pbs_word_t;
  typedef logic [11:0] pbs_addr_t;
  typedef logic [3:0] pbs_mode_t;
  typedef enum logic [5:0] {
    PBS_MODE_STRAP_WAIT = 6'h01,
    PBS_MODE_RUN = 6'h02,
    PBS_MODE_X0 = 6'h04,
    PBS_MODE_X1 = 6'h08,
    PBS_MODE_X2 = 6'h10,
    PBS_MODE_X3 = 6'h20
  } pbs_phase_t;
endpackage

// [rtl/pbs_strap_sync.sv]
// Two-stage synchroniser and reset-time latch for the configuration straps.
`timescale 1ns/1ps
module pbs_strap_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic fund_rst_sync,
  input wire logic [8:0] strap_in,
  output logic [8:0] strap_q
);
  import pbs_pkg::*;

  logic [8:0] meta_q;
  logic [8:0] meta_d;
  logic [8:0] sync_q;
  logic [8:0] sync_d;
  logic [8:0] latch_q;
  logic [8:0] latch_d;

  always_comb begin
    meta_d = strap_in;
    sync_d = meta_q;
    latch_d = latch_q;
    if (fund_rst_sync) begin
      latch_d = sync_q;
    end
  end

  always_ff @(posedge mclk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
    if (sys_rst) begin
      latch_q <= 9'h000;
    end else begin
      latch_q <= latch_d;
    end
  end

  assign strap_q = latch_q;
endmodule

// [rtl/pbs_regs.sv]
// Power budget data value registers and switch status register.
// How it works
// [R01] With the unlock bit set, each of the eight budget words can be read and written.
// [R02] With the unlock bit clear, writes to budget words are dropped and they only read.
// [R03] Budget words are 32 bits, have no reset value and survive every reset.
// [R04] Software or the EEPROM loader is expected to fill the budget words at start.
// [R05] Status bits 3:0 show the operating mode code caught during fundamental reset.
// [R06] Mode codes 0x8 to 0xb are the failover modes, passed on unchanged.
// [R07] The outside party never straps the reserved mode codes.
// [R08] The outside party holds the mode pins steady after fundamental reset ends.
// [R09] Status bit 5 holds the downstream common clock strap caught during reset.
// [R10] Status bit 6 holds the upstream common clock strap caught during reset.
// [R11] Status bit 7 holds the SMBus master slow strap caught during reset.
// [R12] Status bit 8 holds the reference clock mode strap caught during reset.
// [R13] Status bit 9 holds the reset halt strap caught during reset.
// [R14] A data value select above 7 makes the budget data readout return zero.
// [R15] Writes to the status register are ignored and its bit 4 reads zero.
`timescale 1ns/1ps
`include "pbs_cfg.svh"
module pbs_regs (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic fundamental_reset_in_n,
  input wire pbs_pkg::pbs_mode_t operating_mode_code,
  input wire logic downstream_common_clock,
  input wire logic upstream_common_clock,
  input wire logic smbus_master_slow,
  input wire logic reference_clock_mode,
  input wire logic reset_halt_strap,
  input wire pbs_pkg::pbs_addr_t reg_addr,
  input wire pbs_pkg::pbs_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output pbs_pkg::pbs_word_t reg_rdata,
  output logic data_value_unlock,
  output pbs_pkg::pbs_word_t budget_data
);
  import pbs_pkg::*;

  // ****************************************
  // Fundamental reset synchroniser
  // ****************************************
  logic frst_meta_q;
  logic frst_sync_q;
  logic [8:0] strap_q;

  always_ff @(posedge mclk) begin
    frst_meta_q <= ~fundamental_reset_in_n;
    frst_sync_q <= frst_meta_q;
  end

  // Straps are sampled continuously while fundamental reset is held.
  // The latch trails the pins by three cycles, so pins must settle before the reset ends.
  pbs_strap_sync u_strap (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .fund_rst_sync(frst_sync_q),
    .strap_in({reset_halt_strap, reference_clock_mode, smbus_master_slow,
               upstream_common_clock, downstream_common_clock, operating_mode_code}),
    .strap_q(strap_q)
  );

  // ****************************************
  // Control registers
  // ****************************************
  pbs_word_t system_control_q;
  pbs_word_t system_control_d;
  logic [7:0] data_value_select_q;
  logic [7:0] data_value_select_d;
  logic wr_system_control;
  logic wr_data_value_select;

  assign wr_system_control = reg_wr && (reg_addr == `PBS_SYSTEM_CONTROL);
  assign wr_data_value_select = reg_wr && (reg_addr == `PBS_DATA_VALUE_SELECT);

  always_comb begin
    system_control_d = system_control_q;
    data_value_select_d = data_value_select_q;
    if (wr_system_control) begin
      system_control_d = {31'h0000_0000, reg_wdata[`PBS_SYSTEM_CONTROL_UNLOCK_BIT]};
    end
    if (wr_data_value_select) begin
      data_value_select_d = reg_wdata[7:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      system_control_q <= `PBS_SYSTEM_CONTROL_RESET;
      data_value_select_q <= `PBS_DATA_VALUE_SELECT_RESET;
    end else begin
      system_control_q <= system_control_d;
      data_value_select_q <= data_value_select_d;
    end
  end

  assign data_value_unlock = system_control_q[`PBS_SYSTEM_CONTROL_UNLOCK_BIT];

  // ****************************************
  // Budget data value words
  // ****************************************
  // The words have no reset: they are sticky and start undefined.
  pbs_word_t bdv_q [`PBS_NUM_BDV];
  logic [`PBS_NUM_BDV-1:0] bdv_hit;

  genvar gi;
  generate
    for (gi = 0; gi < `PBS_NUM_BDV; gi++) begin : g_bdv
      pbs_word_t bdv_d;
      assign bdv_hit[gi] = reg_addr == (`PBS_BDV_BASE + 12'(gi * 4));
      always_comb begin
        bdv_d = bdv_q[gi];
        if (reg_wr && bdv_hit[gi] && data_value_unlock) begin // [R01] [R02]
          bdv_d = reg_wdata;
        end
      end
      always_ff @(posedge mclk) begin
        bdv_q[gi] <= bdv_d; // [R03]
      end
    end
  endgenerate

  // ****************************************
  // Readout and status
  // ****************************************
  pbs_word_t status_w;
  pbs_word_t rdata_q;
  pbs_word_t rdata_d;
  pbs_word_t bdata_q;
  pbs_word_t bdata_d;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[3:0] = strap_q[3:0]; // [R05] [R06]
    status_w[`PBS_RSVD_BIT] = 1'b0; // [R15]
    status_w[`PBS_DOWNSTREAM_COMMON_CLOCK_BIT] = strap_q[4]; // [R09]
    status_w[`PBS_UPSTREAM_COMMON_CLOCK_BIT] = strap_q[5]; // [R10]
    status_w[`PBS_SMBSLOW_BIT] = strap_q[6]; // [R11]
    status_w[`PBS_REFCLK_BIT] = strap_q[7]; // [R12]
    status_w[`PBS_RESET_HALT_STRAP_BIT] = strap_q[8]; // [R13]
  end

  always_comb begin
    bdata_d = 32'h0000_0000;
    if (data_value_select_q <= `PBS_DATA_VALUE_SELECT_MAX) begin // [R14]
      bdata_d = bdv_q[data_value_select_q[2:0]];
    end
  end

  // Read data stand for one cycle only and are zero when no read was made.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_rd) begin
      if (|bdv_hit) begin
        for (int i = 0; i < `PBS_NUM_BDV; i++) begin
          if (bdv_hit[i]) begin
            rdata_d = bdv_q[i];
          end
        end
      end else if (reg_addr == `PBS_SWITCH_STATUS) begin
        rdata_d = status_w;
      end else if (reg_addr == `PBS_SYSTEM_CONTROL) begin
        rdata_d = system_control_q;
      end else if (reg_addr == `PBS_DATA_VALUE_SELECT) begin
        rdata_d = {24'h00_0000, data_value_select_q};
      end else if (reg_addr == `PBS_BDATA) begin
        rdata_d = bdata_d; // [R14]
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_q <= 32'h0000_0000;
      bdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
      bdata_q <= bdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign budget_data = bdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  AST_LOCKED_WRITE_DROPPED: assert property ( // [R02]
    (reg_wr && bdv_hit[0] && !data_value_unlock) |=> $stable(bdv_q[0]))
    else $error("Budget word changed while locked.");

  AST_UNLOCKED_WRITE_TAKEN: assert property ( // [R01]
    (reg_wr && bdv_hit[3] && data_value_unlock) |=> (bdv_q[3] == $past(reg_wdata)))
    else $error("Unlocked budget write not stored.");

  AST_READBACK_WORD: assert property ( // [R01]
    (reg_rd && bdv_hit[5]) |=> (reg_rdata == $past(bdv_q[5])))
    else $error("Budget word readback wrong.");

  AST_SELECT_ZERO: assert property ( // [R14]
    (data_value_select_q > `PBS_DATA_VALUE_SELECT_MAX) |=> (budget_data == 32'h0000_0000))
    else $error("Out of range select not zero.");

  AST_STATUS_RSVD: assert property ( // [R15]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS) |=> (reg_rdata[31:10] == 22'h0 && !reg_rdata[4]))
    else $error("Status reserved bits not zero.");

  AST_STATUS_STABLE: assert property ( // [R15]
    (!frst_sync_q && !$past(frst_sync_q)) |=> $stable(strap_q))
    else $error("Straps changed outside fundamental reset.");

  AST_MODE_REPORT: assert property ( // [R05]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS) |=> (reg_rdata[3:0] == $past(strap_q[3:0])))
    else $error("Mode code readout wrong.");

  AST_STRAP_BITS: assert property ( // [R09]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS) |=> (reg_rdata[9:5] == $past(strap_q[8:4])))
    else $error("Strap bits readout wrong.");

  AST_LOCK_DEFAULT: assert property ( // [R02]
    $rose(frst_sync_q) |-> ##0 1'b1 ##1 (data_value_unlock == $past(data_value_unlock)
      || $past(wr_system_control)))
    else $error("Unlock bit changed without write.");

  // The checks below look at words whether or not a write has filled them, though unwritten
  // words hold unknown values by design.
  AST_LOCKED_WRITE_LAST: assert property ( // [R02]
    (reg_wr && bdv_hit[7] && !data_value_unlock)
    |=> $stable(bdv_q[7]))
    else $error("Last budget word changed while locked.");

  AST_UNLOCKED_WRITE_FIRST: assert property ( // [R01]
    (reg_wr && bdv_hit[0] && data_value_unlock)
    |=> (bdv_q[0] == $past(reg_wdata)))
    else $error("Unlocked write to first word not stored.");

  AST_READBACK_FIRST: assert property ( // [R01]
    (reg_rd && bdv_hit[0])
    |=> (reg_rdata == $past(bdv_q[0])))
    else $error("First budget word readback wrong.");

  AST_BDATA_SELECTED: assert property ( // [R14]
    (reg_rd && reg_addr == `PBS_BDATA && data_value_select_q <= `PBS_DATA_VALUE_SELECT_MAX)
    |=> (reg_rdata == $past(bdv_q[data_value_select_q[2:0]])))
    else $error("Budget data readout does not follow the select.");

  AST_BDATA_READ_ZERO: assert property ( // [R14]
    (reg_rd && reg_addr == `PBS_BDATA && data_value_select_q > `PBS_DATA_VALUE_SELECT_MAX)
    |=> (reg_rdata == 32'h0000_0000))
    else $error("Budget data readout not zero for a high select.");

  AST_DATA_VALUE_SELECT_UPPER_ZERO: assert property ( // [R14]
    (reg_rd && reg_addr == `PBS_DATA_VALUE_SELECT)
    |=> (reg_rdata[31:8] == 24'h00_0000))
    else $error("Select register upper bits not zero.");

  AST_MODE_FAILOVER: assert property ( // [R06]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS && strap_q[3])
    |=> reg_rdata[3])
    else $error("Failover mode code not reported.");

  AST_STATUS_UP_CLOCK: assert property ( // [R10]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS)
    |=> (reg_rdata[`PBS_UPSTREAM_COMMON_CLOCK_BIT] == $past(strap_q[5])))
    else $error("Upstream common clock bit wrong.");

  AST_STATUS_SMB_SLOW: assert property ( // [R11]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS)
    |=> (reg_rdata[`PBS_SMBSLOW_BIT] == $past(strap_q[6])))
    else $error("Slow mode strap bit wrong.");

  AST_STATUS_REF_CLOCK: assert property ( // [R12]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS)
    |=> (reg_rdata[`PBS_REFCLK_BIT] == $past(strap_q[7])))
    else $error("Reference clock mode bit wrong.");

  AST_STATUS_HALT: assert property ( // [R13]
    (reg_rd && reg_addr == `PBS_SWITCH_STATUS)
    |=> (reg_rdata[`PBS_RESET_HALT_STRAP_BIT] == $past(strap_q[8])))
    else $error("Reset halt bit wrong.");

  AST_STATUS_WRITE_IGNORED: assert property ( // [R15]
    (reg_wr && reg_addr == `PBS_SWITCH_STATUS && !frst_sync_q)
    |=> $stable(strap_q))
    else $error("Status write changed the straps.");

  AST_LOCK_AFTER_RESET: assert property ( // [R02]
    $fell(sys_rst)
    |-> !data_value_unlock)
    else $error("Unlock bit set after reset.");

  // ****************************************
  // Cover points
  // ****************************************
  COV_UNLOCK_WRITE: cover property (reg_wr && |bdv_hit && data_value_unlock);
  COV_LOCK_WRITE: cover property (reg_wr && |bdv_hit && !data_value_unlock);
  COV_SEL_HIGH: cover property (data_value_select_q > `PBS_DATA_VALUE_SELECT_MAX);
  COV_STATUS_READ: cover property (reg_rd && reg_addr == `PBS_SWITCH_STATUS);
  COV_FAILOVER_MODE: cover property (reg_rd && reg_addr == `PBS_SWITCH_STATUS && strap_q[3]);
endmodule

// [sim/tb_pbs_regs.sv]
// Self-checking bench for the budget word and switch status registers.
`timescale 1ns/1ps
`include "pbs_cfg.svh"
module tb_pbs_regs;
  import pbs_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic fund_rst_n = 1'b0;
  pbs_mode_t mode = 4'h0;
  logic [4:0] straps = 5'h00;
  pbs_addr_t addr = 12'h000;
  pbs_word_t wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  pbs_word_t rdata;
  pbs_word_t bdata;
  logic unlock;
  int err_total = 0;
  int checks_done = 0;

  pbs_regs i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .fundamental_reset_in_n(fund_rst_n),
    .operating_mode_code(mode), .downstream_common_clock(straps[0]),
    .upstream_common_clock(straps[1]), .smbus_master_slow(straps[2]),
    .reference_clock_mode(straps[3]), .reset_halt_strap(straps[4]),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .data_value_unlock(unlock), .budget_data(bdata)
  );

  initial begin
    forever #20 mclk = ~mclk;
  end

  task automatic give_verdict();
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input pbs_word_t got, input pbs_word_t exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input pbs_addr_t a, input pbs_word_t d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input pbs_addr_t a, input pbs_word_t exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // Unlocked words take writes, a locked write to the last word is dropped, and word 1 survives a reset.
  task automatic unlock_case();
    wr_reg(`PBS_SYSTEM_CONTROL, 32'hffff_ffff);
    #1 chk({31'h0, unlock}, 32'h0000_0001);
    rd_reg(`PBS_SYSTEM_CONTROL, 32'h0000_0001);
    for (int i = 0; i < `PBS_NUM_BDV; i++) begin
      wr_reg(`PBS_BDV_BASE + 12'(4 * i), 32'hb0d0_0000 | i);
    end
    for (int i = 0; i < `PBS_NUM_BDV; i++) begin
      rd_reg(`PBS_BDV_BASE + 12'(4 * i), 32'hb0d0_0000 | i);
    end
    wr_reg(`PBS_SYSTEM_CONTROL, 32'h0000_0000);
    wr_reg(`PBS_BDV_LAST, 32'hdead_beef);
    rd_reg(`PBS_BDV_LAST, 32'hb0d0_0007);
    @(posedge mclk) sys_rst <= 1'b1;
    @(posedge mclk) sys_rst <= 1'b0;
    #1 chk({31'h0, unlock}, 32'h0000_0000);
    rd_reg(`PBS_BDV_BASE + 12'h004, 32'hb0d0_0001);
  endtask

  // The readout follows the select and gives zero above the last word.
  task automatic select_case(input logic [7:0] sel);
    pbs_word_t exp;
    exp = (sel <= `PBS_DATA_VALUE_SELECT_MAX) ? (32'hb0d0_0000 | sel) : 32'h0000_0000;
    wr_reg(`PBS_DATA_VALUE_SELECT, {24'h0, sel});
    @(posedge mclk);
    #1 chk(bdata, exp);
    rd_reg(`PBS_BDATA, exp);
    rd_reg(`PBS_DATA_VALUE_SELECT, {24'h0, sel});
  endtask

  // Straps caught during fundamental reset stay put afterwards and ignore writes.
  task automatic strap_case(input pbs_mode_t m, input logic [4:0] s);
    @(posedge mclk);
    fund_rst_n <= 1'b0;
    mode <= m;
    straps <= s;
    repeat (6) @(posedge mclk);
    fund_rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    straps <= ~s;
    rd_reg(`PBS_SWITCH_STATUS, {22'h0, s, 1'b0, m});
    wr_reg(`PBS_SWITCH_STATUS, 32'hffff_ffff);
    rd_reg(`PBS_SWITCH_STATUS, {22'h0, s, 1'b0, m});
  endtask

  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    unlock_case();
    select_case(8'h03);
    select_case(8'h07);
    select_case(8'h08);
    select_case(8'hff);
    strap_case(4'h0, 5'h15);
    strap_case(4'h1, 5'h0a);
    strap_case(4'h8, 5'h1f);
    strap_case(4'h9, 5'h00);
    strap_case(4'ha, 5'h01);
    strap_case(4'hb, 5'h10);
    rd_reg(12'h500, 32'h0000_0000);
    give_verdict();
  end
endmodule
